/* cutoff_pkg.sv */
// Constants and types shared by the torque cutoff monitor
package cutoff_pkg;
  // Clock rate
  localparam int unsigned CLK_HZ          = 25000000;
  localparam int unsigned CYC_PER_MS      = CLK_HZ / 1000;
  // Documented times in milliseconds
  localparam int unsigned DISC_MS         = 200;
  localparam int unsigned REACT_EXTRA_MS  = 10;
  localparam int unsigned BREAK_MS        = 1;
  localparam int unsigned RESP_MAX_MS     = 15;
  localparam int unsigned FAULT_IND_MS    = 500;
  localparam int unsigned WARN_IND_MS     = 1000;
  // Cycle counts derived from the times (whole ms, so exact)
  localparam int unsigned BREAK_CYC       = BREAK_MS * CYC_PER_MS;
  localparam int unsigned RESP_MAX_CYC    = RESP_MAX_MS * CYC_PER_MS;
  // Counter width parameters and indication selection reset value
  localparam int unsigned MS_CNT_W        = 16;
  localparam int unsigned TICK_W          = 11;
  localparam logic [1:0]  IND_SEL_RST     = 2'h0;
  // Indication selection codes for normal cutoff operation
  typedef enum logic [1:0] {IND_NONE, IND_WARN, IND_FAULT, IND_EVENT} ind_sel_t;
  // Monitor states
  typedef enum {ST_RUN, ST_CUTOFF, ST_DISC, ST_FAULT} mon_state_t;
endpackage : cutoff_pkg

/* cutoff_switch_model.sv */
// Safety switch model driving the two cutoff channel contacts
`timescale 1ns/1ps
module cutoff_switch_model (
  // Commands from the bench
  input  wire logic cut_all_in,   // Open both contacts together
  input  wire logic drop_one_in,  // Broken contact on channel one
  input  wire logic drop_two_in,  // Broken contact on channel two
  // Contact levels, high = closed
  output logic      ch_one_out,
  output logic      ch_two_out
);
  // One request opens both contacts; a single drop is a wiring fault
  assign ch_one_out = ~(cut_all_in | drop_one_in);
  assign ch_two_out = ~(cut_all_in | drop_two_in);
endmodule : cutoff_switch_model

/* sync_filter.sv */
// Two-stage synchroniser followed by a break qualifier for one cutoff channel
`timescale 1ns/1ps
module sync_filter
  import cutoff_pkg::*;
#(
  parameter int unsigned QUAL_CYC = BREAK_CYC
) (
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic pin_in,      // Raw channel level, high = energised
  output logic      open_out     // Qualified open, high after break held
);
  logic                  meta_ff;  // First stage, read only by second
  logic                  sync_ff;  // Second stage
  logic [MS_CNT_W+4:0]   cnt_ff;   // Length of current open level
  logic [MS_CNT_W+4:0]   nxt_cnt;
  logic                  nxt_open;

  // Count open cycles, clear when energised
  assign nxt_cnt  = sync_ff ? '0 :
                    (cnt_ff == (MS_CNT_W+5)'(QUAL_CYC)) ? cnt_ff : cnt_ff + 1'b1;
  // Open when break held for full qualification time
  assign nxt_open = !sync_ff && (cnt_ff == (MS_CNT_W+5)'(QUAL_CYC - 1));

  // Synchroniser and qualifier registers
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      meta_ff  <= 1'b0;
      sync_ff  <= 1'b0;
      cnt_ff   <= '0;
      open_out <= 1'b1;
    end else begin
      meta_ff  <= pin_in;
      sync_ff  <= meta_ff;
      cnt_ff   <= nxt_cnt;
      open_out <= sync_ff ? 1'b0 : (open_out | nxt_open);
    end
  end
endmodule : sync_filter

/* tb.sv */
// Self-checking bench for the torque cutoff monitor
`timescale 1ns/1ps
module tb;
  import cutoff_pkg::*;
  localparam int TICK = 10;  // Shortened ms tick
  localparam int QUAL = 4;   // Shortened break qualification
  localparam int DISC = 5;   // Shortened discrepancy window in ticks
  logic       clk, rst, start_req, fault_rst, cut_all, drop_one, drop_two;
  logic       ch_one, ch_two, gate, hw_fault, loss_one, loss_two, f_ind, w_ind, e_ind;
  logic [1:0] ind_sel;       // Normal cutoff indication kind
  int         mismatches, comparisons, n;

  torque_cutoff_monitor #(.TICK_CYC(TICK), .QUAL_CYC(QUAL), .DISC_TICKS(DISC)) i_dut (
    .CLOCK_IN(clk), .RESET_IN(rst), .CUTOFF_CHANNEL_ONE_IN(ch_one),
    .CUTOFF_CHANNEL_TWO_IN(ch_two), .START_REQ_IN(start_req), .FAULT_RESET_IN(fault_rst),
    .IND_SEL_IN(ind_sel), .GATE_ENABLE_OUT(gate), .HW_FAULT_OUT(hw_fault),
    .CHANNEL_ONE_LOSS_FAULT_OUT(loss_one), .CHANNEL_TWO_LOSS_FAULT_OUT(loss_two),
    .FAULT_IND_OUT(f_ind), .WARN_IND_OUT(w_ind), .EVENT_IND_OUT(e_ind));

  cutoff_switch_model i_switch (.cut_all_in(cut_all), .drop_one_in(drop_one),
    .drop_two_in(drop_two), .ch_one_out(ch_one), .ch_two_out(ch_two));

  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Compare one output bit
  task automatic check(input string what, input logic seen, input logic exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %b seen %b", what, exp, seen);
    end
  endtask : check

  // Verdict and end of run
  task automatic final_report;
    if (mismatches == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : final_report

  // Wait falling edges
  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask : cyc

  // Bounded wait for gate (0) or fault (1) to reach a level
  task automatic wait_out(input int sel, input logic v, input int max, output int cnt);
    cnt = 0;
    while ((sel == 0 ? gate : hw_fault) !== v && cnt < max) begin
      @(negedge clk);
      cnt++;
    end
  endtask : wait_out

  // Fault reset pulse
  task automatic pulse_reset;
    fault_rst = 1'b1;
    cyc(1);
    fault_rst = 1'b0;
    cyc(3);
  endtask : pulse_reset

  // Start pulse, then gate must follow the expectation
  task automatic do_start(input logic exp);
    start_req = 1'b1;
    cyc(1);
    start_req = 1'b0;
    wait_out(0, exp, 10, n);
    cyc(2);
    check("gate after start", gate, exp);
  endtask : do_start

  // Both channels opened with each indication kind
  task automatic t_cutoff;
    for (int k = 0; k < 4; k++) begin
      cut_all = 1'b1;
      wait_out(0, 1'b0, QUAL + 8, n);
      check("gate on cutoff", gate, 1'b0);
      ind_sel = 2'(k);
      cyc(3);
      check("fault ind", f_ind, k == 2);
      check("warn ind", w_ind, k == 1);
      check("event ind", e_ind, k == 3);
      check("no fault when agreeing", hw_fault, 1'b0);
      do_start(1'b0);
      cut_all = 1'b0;
      ind_sel = 2'h0;
      cyc(4);
      pulse_reset();
      do_start(1'b1);
    end
  endtask : t_cutoff

  // Short break ignored, qualified break trips the gate
  task automatic t_break;
    cut_all = 1'b1;
    cyc(2);
    cut_all = 1'b0;
    cyc(20);
    check("short break", gate, 1'b1);
    cut_all = 1'b1;
    cyc(QUAL + 3);
    cut_all = 1'b0;
    cyc(10);
    check("break caught", gate, 1'b0);
    pulse_reset();
    do_start(1'b1);
  endtask : t_break

  // Single channel open: short one tolerated, long one trips
  task automatic t_disc(input logic one);
    drop_one = one;
    drop_two = ~one;
    cyc(30);
    {drop_one, drop_two} = 2'h0;
    cyc(80);
    check("short discrepancy", hw_fault, 1'b0);
    drop_one = one;
    drop_two = ~one;
    wait_out(1, 1'b1, DISC * TICK + TICK + QUAL + 12, n);
    check("not before window", n >= DISC * TICK + QUAL + 2, 1'b1);
    check("trip", hw_fault, 1'b1);
    check("loss one", loss_one, one);
    check("loss two", loss_two, ~one);
    cyc(10);
    check("gate off", gate, 1'b0);
    check("fault ind on trip", f_ind, 1'b1);
    do_start(1'b0);
    pulse_reset();
    check("reset while differing", hw_fault, 1'b1);
    {drop_one, drop_two} = 2'h0;
    cyc(8);
    pulse_reset();
    check("fault cleared", hw_fault, 1'b0);
    do_start(1'b1);
  endtask : t_disc

  // Main sequence
  initial begin
    {rst, start_req, fault_rst, cut_all, drop_one, drop_two} = 6'h20;
    ind_sel = 2'h0;
    cyc(6);
    rst = 1'b0;
    cyc(1);
    check("reset gate", gate, 1'b0);
    check("reset fault", hw_fault, 1'b0);
    cyc(8);
    do_start(1'b1);
    t_cutoff();
    t_break();
    t_disc(1'b1);
    t_disc(1'b0);
    final_report();
  end

  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    final_report();
  end
endmodule : tb

/* torque_cutoff_monitor.sv */
// Dual-channel torque cutoff monitor: compare, time, trip and indicate
// Contract
// - Continuously compare the two cutoff channels
// - Discrepancy fault only after 200 ms disagreement
// - Trip within detection time plus 10 ms
// - Single channel activation trips same fault
// - Detect input breaks as short as 1 ms
// - Remove switch drive within 15 ms
// - Fault indication within 500 ms
// - Warning indication within 1000 ms
// - Normal cutoff indication follows software selection
// - Both open removes drive, no restart
// - Faults reset before new start accepted
`timescale 1ns/1ps
module torque_cutoff_monitor
  import cutoff_pkg::*;
#(
  parameter int unsigned TICK_CYC  = CYC_PER_MS,   // Cycles per ms tick
  parameter int unsigned QUAL_CYC  = BREAK_CYC,    // Break qualification
  parameter int unsigned DISC_TICKS = DISC_MS      // Discrepancy window, ms
) (
  // Clock and reset
  input  wire logic       CLOCK_IN,
  input  wire logic       RESET_IN,
  // Cutoff channel pins, high = energised (run permitted)
  input  wire logic       CUTOFF_CHANNEL_ONE_IN,
  input  wire logic       CUTOFF_CHANNEL_TWO_IN,
  // Drive control side
  input  wire logic       START_REQ_IN,        // Start command pulse
  input  wire logic       FAULT_RESET_IN,      // Fault reset pulse
  input  wire logic [1:0] IND_SEL_IN,          // Normal-cutoff indication kind
  // Outputs
  output logic            GATE_ENABLE_OUT,     // Drive to power switches
  output logic            HW_FAULT_OUT,        // Latched hardware-failure fault
  output logic            CHANNEL_ONE_LOSS_FAULT_OUT,
  output logic            CHANNEL_TWO_LOSS_FAULT_OUT,
  output logic            FAULT_IND_OUT,       // Fault indication
  output logic            WARN_IND_OUT,        // Warning indication
  output logic            EVENT_IND_OUT        // Event indication
);
  // Qualified open levels per channel
  logic                 open_one;
  logic                 open_two;
  // Millisecond tick
  logic [TICK_W+4:0]    tick_cnt_ff;
  logic                 tick_ff;
  // Discrepancy timer in ms
  logic [MS_CNT_W-1:0]  disc_cnt_ff;
  logic [MS_CNT_W-1:0]  nxt_disc_cnt;
  // State and latched faults
  mon_state_t           state_ff;
  mon_state_t           nxt_state;
  logic                 loss_one_ff;
  logic                 loss_two_ff;
  logic                 run_ff;          // Start accepted, drive running
  ind_sel_t             sel_ff;          // Registered indication selection

  // Channel conditioning
  sync_filter #(.QUAL_CYC(QUAL_CYC)) u_ch_one (
    .clk_in   (CLOCK_IN),
    .rst_in   (RESET_IN),
    .pin_in   (CUTOFF_CHANNEL_ONE_IN),
    .open_out (open_one)
  );
  sync_filter #(.QUAL_CYC(QUAL_CYC)) u_ch_two (
    .clk_in   (CLOCK_IN),
    .rst_in   (RESET_IN),
    .pin_in   (CUTOFF_CHANNEL_TWO_IN),
    .open_out (open_two)
  );

  // Decoded conditions
  wire differ    = open_one ^ open_two;
  wire both_open = open_one & open_two;
  wire disc_hit  = differ && tick_ff &&
                   (disc_cnt_ff == MS_CNT_W'(DISC_TICKS));
  wire faulted   = (state_ff == ST_FAULT);
  wire can_clear = FAULT_RESET_IN && !differ;
  wire cutoff_on = both_open || faulted || differ;
  wire start_ok  = START_REQ_IN && !cutoff_on && !faulted;

  // Discrepancy counter advances on ms ticks while channels differ
  assign nxt_disc_cnt = !differ ? '0 :
                        (tick_ff && disc_cnt_ff != MS_CNT_W'(DISC_TICKS)) ?
                        disc_cnt_ff + 1'b1 : disc_cnt_ff;

  // Next state
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_RUN: begin
        if (differ) nxt_state = ST_DISC;
        else if (both_open) nxt_state = ST_CUTOFF;
      end
      ST_CUTOFF: begin
        if (differ) nxt_state = ST_DISC;
        else if (!both_open) nxt_state = ST_RUN;
      end
      ST_DISC: begin
        if (disc_hit) nxt_state = ST_FAULT;
        else if (!differ) nxt_state = both_open ? ST_CUTOFF : ST_RUN;
      end
      ST_FAULT: begin
        if (can_clear) nxt_state = both_open ? ST_CUTOFF : ST_RUN;
      end
      default: nxt_state = ST_RUN;
    endcase
  end

  // Free-running millisecond tick
  always_ff @(posedge CLOCK_IN) begin
    if (RESET_IN) begin
      tick_cnt_ff <= '0;
      tick_ff     <= 1'b0;
    end else begin
      tick_ff     <= (tick_cnt_ff == (TICK_W+5)'(TICK_CYC - 1));
      tick_cnt_ff <= (tick_cnt_ff == (TICK_W+5)'(TICK_CYC - 1)) ? '0 :
                     tick_cnt_ff + 1'b1;
    end
  end

  // State, timer, selection
  always_ff @(posedge CLOCK_IN) begin
    if (RESET_IN) begin
      state_ff    <= ST_RUN;
      disc_cnt_ff <= '0;
      sel_ff      <= IND_NONE;
    end else begin
      state_ff    <= nxt_state;
      disc_cnt_ff <= nxt_disc_cnt;
      sel_ff      <= ind_sel_t'(IND_SEL_IN);
    end
  end

  // Per-channel loss faults, set wins over reset
  always_ff @(posedge CLOCK_IN) begin
    if (RESET_IN) begin
      loss_one_ff <= 1'b0;
      loss_two_ff <= 1'b0;
    end else begin
      loss_one_ff <= (disc_hit && open_one) || (loss_one_ff && !can_clear);
      loss_two_ff <= (disc_hit && open_two) || (loss_two_ff && !can_clear);
    end
  end

  // Run permission: needs a start, dropped on any cutoff
  always_ff @(posedge CLOCK_IN) begin
    if (RESET_IN) begin
      run_ff <= 1'b0;
    end else if (cutoff_on) begin
      run_ff <= 1'b0;
    end else if (start_ok) begin
      run_ff <= 1'b1;
    end
  end

  // Registered outputs
  always_ff @(posedge CLOCK_IN) begin
    if (RESET_IN) begin
      GATE_ENABLE_OUT            <= 1'b0;
      HW_FAULT_OUT               <= 1'b0;
      CHANNEL_ONE_LOSS_FAULT_OUT <= 1'b0;
      CHANNEL_TWO_LOSS_FAULT_OUT <= 1'b0;
      FAULT_IND_OUT              <= 1'b0;
      WARN_IND_OUT               <= 1'b0;
      EVENT_IND_OUT              <= 1'b0;
    end else begin
      GATE_ENABLE_OUT            <= run_ff && !cutoff_on;
      HW_FAULT_OUT               <= faulted;
      CHANNEL_ONE_LOSS_FAULT_OUT <= loss_one_ff;
      CHANNEL_TWO_LOSS_FAULT_OUT <= loss_two_ff;
      // Fault indication: hardware fault or selected for normal cutoff
      FAULT_IND_OUT <= faulted || (both_open && sel_ff == IND_FAULT);
      WARN_IND_OUT  <= !faulted && both_open && sel_ff == IND_WARN;
      EVENT_IND_OUT <= !faulted && both_open && sel_ff == IND_EVENT;
    end
  end

  // Assertion helpers: cycles since both channels went low at the pins
  logic [20:0] both_low_cnt_ff;
  always_ff @(posedge CLOCK_IN) begin
    if (RESET_IN || CUTOFF_CHANNEL_ONE_IN || CUTOFF_CHANNEL_TWO_IN) begin
      both_low_cnt_ff <= '0;
    end else if (both_low_cnt_ff != 21'h1fffff) begin
      both_low_cnt_ff <= both_low_cnt_ff + 1'b1;
    end
  end

  // Drive drops a few cycles after qualification, never past the maximum
  localparam int unsigned RESP_CHK_CYC = (QUAL_CYC + 8 < RESP_MAX_CYC) ?
                                         QUAL_CYC + 8 : RESP_MAX_CYC;

  // Assertion helper: cycles the qualified channels have disagreed
  logic [23:0] differ_cnt_ff;
  always_ff @(posedge CLOCK_IN) begin
    if (RESET_IN || !differ) begin
      differ_cnt_ff <= '0;
    end else if (differ_cnt_ff != 24'hffffff) begin
      differ_cnt_ff <= differ_cnt_ff + 1'b1;
    end
  end

  property p_resp;
    @(posedge CLOCK_IN) disable iff (RESET_IN)
      (both_low_cnt_ff >= 21'(RESP_CHK_CYC)) |-> !GATE_ENABLE_OUT;
  endproperty
  a_resp: assert property (p_resp) else $error("Drive not removed in time");

  property p_short;
    @(posedge CLOCK_IN) disable iff (RESET_IN)
      (state_ff == ST_DISC && !differ) |=> state_ff != ST_FAULT;
  endproperty
  a_short: assert property (p_short) else $error("Fault without discrepancy");

  property p_window;
    @(posedge CLOCK_IN) disable iff (RESET_IN)
      disc_hit |-> (differ_cnt_ff >= 24'(DISC_TICKS * TICK_CYC));
  endproperty
  a_window: assert property (p_window) else $error("Discrepancy fault too early");

  property p_trip;
    @(posedge CLOCK_IN) disable iff (RESET_IN)
      (disc_hit && !faulted) |=> HW_FAULT_OUT == 1'b0 ##1 HW_FAULT_OUT;
  endproperty
  a_trip: assert property (p_trip) else $error("Trip not raised after detection");

  property p_cmp;
    @(posedge CLOCK_IN) disable iff (RESET_IN)
      (differ && state_ff != ST_FAULT) |=> state_ff inside {ST_DISC, ST_FAULT};
  endproperty
  a_cmp: assert property (p_cmp) else $error("Mismatch not tracked");

  property p_latch;
    @(posedge CLOCK_IN) disable iff (RESET_IN)
      (faulted && !can_clear) |=> faulted;
  endproperty
  a_latch: assert property (p_latch) else $error("Fault dropped without reset");

  property p_norun;
    @(posedge CLOCK_IN) disable iff (RESET_IN)
      both_open |=> ##1 !GATE_ENABLE_OUT;
  endproperty
  a_norun: assert property (p_norun) else $error("Drive enabled while open");

  property p_start;
    @(posedge CLOCK_IN) disable iff (RESET_IN)
      (!run_ff && faulted) |=> !run_ff;
  endproperty
  a_start: assert property (p_start) else $error("Start taken while faulted");

  property p_find;
    @(posedge CLOCK_IN) disable iff (RESET_IN)
      faulted |=> FAULT_IND_OUT;
  endproperty
  a_find: assert property (p_find) else $error("Fault indication late");

  property p_wind;
    @(posedge CLOCK_IN) disable iff (RESET_IN)
      (!faulted && both_open && sel_ff == IND_WARN) |=> WARN_IND_OUT;
  endproperty
  a_wind: assert property (p_wind) else $error("Warning indication late");
endmodule : torque_cutoff_monitor
